// >>> verilog/eeprom_protect.v
// Purpose: write protection, latch and pin control of a serial eeprom slave
// Assumes: serial pins sampled by sys_clk through three flops; sclk far slower
// Notes: array writes leave as a byte stream plus commit pulse, no array here
//
// Operation
// R1: block-protect pair guards none, 1800h up, 1000h up or the whole array
// R2: hardware protection needs pin low and pin-enable bit set together
// R3: hardware protection blocks only nonvolatile status updates, nothing else
// R4: a valid status write starts the timed write cycle on select rising
// R5: write-enable latch is clear after power-up
// R6: latch clears after any completed byte, page or status write
// R7: host must end write sequences on an exact byte boundary
// R8: array access during a write cycle is ignored; the cycle completes
// R9: power-on in standby, latch clear, output released; select must fall first
// R10: select high deselects, but a running write cycle still completes
// R11: output released while deselected
// R12: input latched on clock rise, output changed after clock fall
// R13: protect pin low during status write blocks it; later falls do not
// R14: host keeps pause high when not pausing
// R15: pause taken while clock low, else deferred to next clock fall
// R16: paused: sequence kept, pin transitions ignored, output released
// R17: resume only when pause rises while clock low
// R18: host keeps select low across a pause
// R19: pause low releases the serial output at once
// R20: write-enable opcode 06h sets latch, write-disable 04h clears it
// R21: latch state readable as status bit 1; gates array writes
// R22: status write is opcode then one data byte, msb first
`timescale 1ns/100ps
`include "eeprom_protect_consts.vh"
module eeprom_protect #(
    parameter WRITE_CYCLES = `WRITE_CYCLE_CYC,
    parameter FIFO_DEPTH = 16
) (
    input wire sys_clk,
    input wire rst_n,
    input wire sel_n_pin,
    input wire sclk_pin,
    input wire sdi_pin,
    input wire pause_n_pin,
    input wire wprot_n_pin,
    output reg sdo_out_q,
    output reg sdo_oe_n_q,
    output reg [7:0] status_q,
    output reg protect_pin_enable,
    output reg block_protect_hi,
    output reg block_protect_lo,
    output reg write_enable_latch,
    output reg write_in_progress,
    output reg [12:0] wr_addr_q,
    output reg [7:0] wr_data_q,
    output reg wr_data_valid_q,
    input wire wr_data_ready,
    output reg array_commit_q,
    output reg write_refused_q,
    output reg paused_q
);
    // states of the serial sequence, one-hot
    localparam [5:0] ST_IDLE = 6'b00_0001;
    localparam [5:0] ST_OPC = 6'b00_0010;
    localparam [5:0] ST_ADDR = 6'b00_0100;
    localparam [5:0] ST_WDATA = 6'b00_1000;
    localparam [5:0] ST_SDATA = 6'b01_0000;
    localparam [5:0] ST_OUT = 6'b10_0000;

    // three-flop samplers for every pin
    reg [2:0] sel_s_q;
    reg [2:0] sck_s_q;
    reg [2:0] sdi_s_q;
    reg [2:0] hold_s_q;
    reg [2:0] wp_s_q;
    reg sel_n_q;
    reg sck_q;
    reg hold_n_q;
    reg [5:0] state_q;
    reg [4:0] bit_cnt_q;
    reg [7:0] shift_q;
    reg [7:0] opcode_q;
    reg [15:0] addr_sh_q;
    reg [7:0] sr_new_q;
    reg sr_pending_q;
    reg wr_pending_q;
    reg wr_any_q;
    reg [31:0] wc_cnt_q;
    reg [7:0] out_sh_q;
    reg fifo_out_ready_q;
    wire sel_n_d;
    wire sck_d;
    wire hold_n_d;
    wire sck_rise;
    wire sck_fall;
    wire sel_rise;
    wire sel_fall;
    wire hw_prot;
    wire addr_prot;
    wire [7:0] shift_d;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [7:0] fifo_out_data;
    wire byte_done;
    wire refuse_now;

    // a level counts once flops two and three agree
    assign sel_n_d = (sel_s_q[2] == sel_s_q[1]) ? sel_s_q[1] : sel_n_q;
    assign sck_d = (sck_s_q[2] == sck_s_q[1]) ? sck_s_q[1] : sck_q;
    assign hold_n_d = (hold_s_q[2] == hold_s_q[1]) ? hold_s_q[1] : hold_n_q;

    // events; clock edges are ignored while paused or deselected
    assign sck_rise = sck_d && !sck_q && !sel_n_q && hold_n_q; // R16
    assign sck_fall = !sck_d && sck_q && !sel_n_q && hold_n_q; // R16
    assign sel_rise = sel_n_d && !sel_n_q;
    assign sel_fall = !sel_n_d && sel_n_q;
    assign shift_d = {shift_q[6:0], sdi_s_q[2]};
    assign byte_done = sck_rise && (bit_cnt_q[2:0] == 3'd7);

    // hardware protection only with pin low and enable bit set
    assign hw_prot = !wp_s_q[2] && protect_pin_enable; // R2

    // block-protect address decode of the target address
    assign addr_prot = ({block_protect_hi, block_protect_lo} == 2'b11) ||
        ({block_protect_hi, block_protect_lo} == 2'b10 && addr_sh_q[12:0] >= `PROT_HALF_BASE) ||
        ({block_protect_hi, block_protect_lo} == 2'b01 && addr_sh_q[12:0] >= `PROT_QTR_BASE); // R1

    // a completed write sequence that the latch or protection turns away
    assign refuse_now = sel_rise && !write_in_progress &&
        ((sr_pending_q && (!write_enable_latch || hw_prot)) || // R1 R13
        (wr_pending_q && opcode_q == `OP_WRITE && (!write_enable_latch || addr_prot)));

    // pin sampling and level filters
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            sel_s_q <= 3'b111;
            sck_s_q <= 3'b000;
            sdi_s_q <= 3'b000;
            hold_s_q <= 3'b111;
            wp_s_q <= 3'b111;
            sel_n_q <= 1'b1;
            sck_q <= 1'b0;
            hold_n_q <= 1'b1;
        end else begin
            sel_s_q <= {sel_s_q[1:0], sel_n_pin};
            sck_s_q <= {sck_s_q[1:0], sclk_pin};
            sdi_s_q <= {sdi_s_q[1:0], sdi_pin};
            hold_s_q <= {hold_s_q[1:0], pause_n_pin};
            wp_s_q <= {wp_s_q[1:0], wprot_n_pin};
            sel_n_q <= sel_n_d;
            sck_q <= sck_d;
            // pause enters or leaves only while the clock is low; select high ends it at once
            if (hold_n_d != hold_n_q && !sck_d) begin
                hold_n_q <= hold_n_d; // R15 R17
            end
            if (sel_n_d) begin
                hold_n_q <= 1'b1;
            end
        end
    end

    // serial sequence decoder, latched on clock rise
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            state_q <= ST_IDLE; // R9
            bit_cnt_q <= 5'd0;
            shift_q <= 8'h00;
            opcode_q <= 8'h00;
            addr_sh_q <= 16'h0000;
            sr_new_q <= 8'h00;
            sr_pending_q <= 1'b0;
            wr_pending_q <= 1'b0;
            wr_any_q <= 1'b0;
            write_refused_q <= 1'b0;
        end else begin
            write_refused_q <= refuse_now; // R13
            if (sel_n_q) begin
                state_q <= ST_IDLE;
                bit_cnt_q <= 5'd0;
                sr_pending_q <= 1'b0;
                wr_pending_q <= 1'b0;
                if (sel_fall) begin
                    state_q <= ST_OPC; // R9
                end
            end else if (sck_rise) begin
                shift_q <= shift_d; // R12
                bit_cnt_q <= bit_cnt_q + 5'd1;
                // any further bit after a full byte spoils a pending commit
                sr_pending_q <= 1'b0; // R7
                wr_pending_q <= 1'b0; // R7
                case (state_q)
                    ST_OPC: begin
                        if (byte_done) begin
                            opcode_q <= shift_d;
                            bit_cnt_q <= 5'd0;
                            if (write_in_progress && shift_d != `OP_STATUS_READ) begin
                                state_q <= ST_IDLE; // R8
                            end else if (shift_d == `OP_READ || shift_d == `OP_WRITE) begin
                                state_q <= ST_ADDR;
                            end else if (shift_d == `OP_STATUS_WRITE) begin
                                state_q <= ST_SDATA;
                            end else if (shift_d == `OP_STATUS_READ) begin
                                state_q <= ST_OUT;
                            end else begin
                                state_q <= ST_IDLE;
                                wr_pending_q <= (shift_d == `OP_WRITE_ENABLE) ||
                                    (shift_d == `OP_WRITE_DISABLE);
                            end
                        end
                    end
                    ST_ADDR: begin
                        addr_sh_q <= {addr_sh_q[14:0], sdi_s_q[2]};
                        if (bit_cnt_q == 5'd15) begin
                            bit_cnt_q <= 5'd0;
                            wr_any_q <= 1'b0;
                            state_q <= (opcode_q == `OP_WRITE) ? ST_WDATA : ST_OUT;
                        end
                    end
                    ST_WDATA: begin
                        if (byte_done) begin
                            bit_cnt_q <= 5'd0;
                            wr_any_q <= 1'b1;
                            wr_pending_q <= 1'b1;
                        end
                    end
                    ST_SDATA: begin
                        if (byte_done) begin
                            sr_new_q <= shift_d; // R22
                            sr_pending_q <= 1'b1;
                            state_q <= ST_IDLE;
                        end
                    end
                    default: begin
                        bit_cnt_q <= 5'd0;
                    end
                endcase
            end
        end
    end

    // latch, status bits and the self-timed write cycle
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            write_enable_latch <= 1'b0; // R5
            write_in_progress <= 1'b0;
            protect_pin_enable <= 1'b0;
            block_protect_hi <= 1'b0;
            block_protect_lo <= 1'b0;
            wc_cnt_q <= 32'd0;
            array_commit_q <= 1'b0;
            status_q <= `SR_RESET;
        end else begin
            array_commit_q <= 1'b0;
            status_q <= {protect_pin_enable, 3'b000, block_protect_hi, block_protect_lo,
                write_enable_latch, write_in_progress}; // R21
            if (write_in_progress) begin
                // runs to the end whatever select or the pin do
                if (wc_cnt_q == 32'd1) begin
                    write_in_progress <= 1'b0; // R10
                    write_enable_latch <= 1'b0; // R6
                end
                wc_cnt_q <= wc_cnt_q - 32'd1;
            end else if (sel_rise && wr_pending_q && opcode_q == `OP_WRITE_ENABLE) begin
                write_enable_latch <= 1'b1; // R20
            end else if (sel_rise && wr_pending_q && opcode_q == `OP_WRITE_DISABLE) begin
                write_enable_latch <= 1'b0; // R20
            end else if (sel_rise && sr_pending_q && write_enable_latch) begin
                // protect pin judged at commit; later falls cannot abort
                if (!hw_prot) begin
                    protect_pin_enable <= sr_new_q[`SR_PIN_EN_BIT]; // R3 R13
                    block_protect_hi <= sr_new_q[`SR_BP_HI_BIT];
                    block_protect_lo <= sr_new_q[`SR_BP_LO_BIT];
                    write_in_progress <= 1'b1; // R4
                    wc_cnt_q <= WRITE_CYCLES;
                end
            end else if (sel_rise && wr_pending_q && opcode_q == `OP_WRITE &&
                write_enable_latch && !addr_prot) begin
                write_in_progress <= 1'b1; // R1
                wc_cnt_q <= WRITE_CYCLES;
                array_commit_q <= 1'b1;
            end
        end
    end

    // pause indication, follows the filtered pause level
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            paused_q <= 1'b0;
        end else begin
            paused_q <= !hold_n_q;
        end
    end

    // start address of the data bytes, latched before the first byte is done
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            wr_addr_q <= 13'h0000;
        end else if (state_q == ST_WDATA && !wr_any_q) begin
            wr_addr_q <= addr_sh_q[12:0];
        end
    end

    // status readout shifted after clock fall, released when idle or paused
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            sdo_out_q <= 1'b0;
            sdo_oe_n_q <= 1'b1; // R9
            out_sh_q <= 8'h00;
        end else begin
            if (sel_n_q || !hold_s_q[2] || !hold_n_q) begin
                sdo_oe_n_q <= 1'b1; // R11 R19
            end else if (state_q == ST_OUT && sck_fall) begin
                sdo_oe_n_q <= 1'b0;
            end
            if (state_q != ST_OUT) begin
                out_sh_q <= status_q;
            end else if (sck_fall) begin
                sdo_out_q <= out_sh_q[7]; // R12
                out_sh_q <= {out_sh_q[6:0], 1'b0};
            end
        end
    end

    // downstream drain register
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            wr_data_q <= 8'h00;
            wr_data_valid_q <= 1'b0;
            fifo_out_ready_q <= 1'b0;
        end else begin
            fifo_out_ready_q <= !wr_data_valid_q || wr_data_ready;
            if (fifo_out_valid && fifo_out_ready_q && (!wr_data_valid_q || wr_data_ready)) begin
                wr_data_q <= fifo_out_data;
                wr_data_valid_q <= 1'b1;
            end else if (wr_data_ready) begin
                wr_data_valid_q <= 1'b0;
            end
        end
    end

    byte_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH),
        .AW(4)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .in_valid(state_q == ST_WDATA && byte_done),
        .in_ready(fifo_in_ready),
        .in_data(shift_d),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready_q && (!wr_data_valid_q || wr_data_ready)),
        .out_data(fifo_out_data)
    );
endmodule // eeprom_protect

// >>> verilog/eeprom_protect_consts.vh
// Purpose: constants for the serial eeprom protection and pin logic
// Assumes: 8-bit opcodes, 13-bit array address, 50 MHz sys_clk
// Notes: definitions only
`ifndef EEPROM_PROTECT_CONSTS_VH
`define EEPROM_PROTECT_CONSTS_VH
`define OP_READ 8'h03
`define OP_WRITE 8'h02
`define OP_WRITE_DISABLE 8'h04
`define OP_WRITE_ENABLE 8'h06
`define OP_STATUS_READ 8'h05
`define OP_STATUS_WRITE 8'h01
`define SR_PIN_EN_BIT 7
`define SR_BP_HI_BIT 3
`define SR_BP_LO_BIT 2
`define SR_WEL_BIT 1
`define SR_WIP_BIT 0
`define SR_RESET 8'h00
`define PROT_QTR_BASE 13'h1800
`define PROT_HALF_BASE 13'h1000
`define SYS_CLK_MHZ 50
`define WRITE_CYCLE_US 5000
`define WRITE_CYCLE_CYC (`WRITE_CYCLE_US * `SYS_CLK_MHZ)
`endif

// >>> verilog/byte_fifo.v
// Purpose: small synchronous fifo for received data bytes
// Assumes: single clock, synchronous active-low reset
// Notes: valid/ready on both sides; full and empty are exact
`timescale 1ns/100ps
module byte_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire sys_clk,
    input wire rst_n,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_q;
    reg [AW-1:0] rd_ptr_q;
    reg [AW:0] count_q;
    wire push;
    wire pop;

    // handshakes; full stalls the writer
    assign in_ready = (count_q != DEPTH[AW:0]);
    assign out_valid = (count_q != {(AW+1){1'b0}});
    assign out_data = mem_q[rd_ptr_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // storage has no reset, only pointers and count do
    always @(posedge sys_clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    // pointer and occupancy bookkeeping
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            count_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_q + 1'b1;
            end
            if (push && !pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop && !push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end
endmodule // byte_fifo

// >>> sim/eeprom_protect_monitor.sv
// Purpose: port-level checks on the eeprom protection block
// Assumes: single sys_clk domain, synchronous active-low rst_n
// Notes: bound from the testbench top file
`timescale 1ns/100ps
module eeprom_protect_monitor #(
    parameter WRITE_CYCLES = 600
) (
    input wire sys_clk,
    input wire rst_n,
    input wire sel_n_pin,
    input wire pause_n_pin,
    input wire wprot_n_pin,
    input wire sdo_oe_n_q,
    input wire [7:0] status_q,
    input wire protect_pin_enable,
    input wire block_protect_hi,
    input wire block_protect_lo,
    input wire write_enable_latch,
    input wire write_in_progress,
    input wire array_commit_q
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    reg [15:0] wip_cnt_q;
    // length of the running write cycle, cleared between cycles
    always @(posedge sys_clk) begin
        if (!rst_n || !write_in_progress) wip_cnt_q <= 16'h0000;
        else wip_cnt_q <= wip_cnt_q + 16'h0001;
    end
    wire [2:0] nv_bits = {protect_pin_enable, block_protect_hi, block_protect_lo};
    a_reset_state: assert property ($rose(rst_n) |-> !write_enable_latch && sdo_oe_n_q)
        else $error("latch set or output driven after reset");
    a_wip_length: assert property ($fell(write_in_progress) |-> wip_cnt_q == WRITE_CYCLES)
        else $error("write cycle length off");
    a_latch_end: assert property ($fell(write_in_progress) |-> ##[0:2] !write_enable_latch)
        else $error("latch not cleared at end of write cycle");
    a_status_mirror: assert property (status_q == {$past(protect_pin_enable), 3'b000,
        $past(block_protect_hi), $past(block_protect_lo), $past(write_enable_latch),
        $past(write_in_progress)}) else $error("status byte does not follow bits");
    a_nv_on_cycle: assert property ($changed(nv_bits) |-> $rose(write_in_progress))
        else $error("nonvolatile bits changed outside a cycle start");
    a_hw_lock: assert property ($changed(nv_bits) |->
        !$past(protect_pin_enable) || $past(wprot_n_pin, 4))
        else $error("status written while hardware protected");
    a_commit_gate: assert property (array_commit_q |->
        write_enable_latch && !$past(write_in_progress))
        else $error("array commit without latch or during cycle");
    a_pause_release: assert property (!pause_n_pin [*5] |-> sdo_oe_n_q)
        else $error("output driven while paused");
    a_desel_release: assert property (sel_n_pin [*6] |-> sdo_oe_n_q)
        else $error("output driven while deselected");
    c_commit: cover property (array_commit_q);
    c_cycle_end: cover property ($fell(write_in_progress));
    c_pause: cover property (!pause_n_pin [*5]);
endmodule // eeprom_protect_monitor

// >>> sim/spi_host_model.sv
// Purpose: behavioural serial host driving select, clock, data and pause
// Assumes: clock idles low, 160 ns clock period from 4+4 sys_clk
// Notes: data line is not pulled, so it is inverted once released
`timescale 1ns/100ps
module spi_host_model (
    input wire sys_clk,
    output reg sel_n,
    output reg sclk,
    output reg sdi,
    output reg pause_n
);
    // idle: deselected, pause released, clock still
    initial begin
        sel_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
        pause_n = 1'b1;
    end
    task half;
        repeat (4) @(negedge sys_clk);
    endtask
    // data changes only while the clock is low, msb first
    task send(input [7:0] b);
        integer i;
        for (i = 7; i >= 0; i = i - 1) begin
            sdi = b[i];
            half;
            sclk = 1'b1;
            half;
            sclk = 1'b0;
        end
    endtask
    // clock toggles during the pause must be ignored by the device
    task hold(input integer toggles);
        integer i;
        pause_n = 1'b0;
        half;
        for (i = 0; i < toggles; i = i + 1) begin
            sclk = ~sclk;
            half;
        end
        pause_n = 1'b1;
        half;
    endtask
    task frame(input [7:0] op, input [23:0] pl, input integer nb, input bit pz);
        integer k;
        sel_n = 1'b0;
        half;
        send(op);
        if (pz) hold(6);
        for (k = nb - 1; k >= 0; k = k - 1) send(pl[8*k +: 8]);
        half;
        sel_n = 1'b1;
        sdi = ~sdi;
        half;
        half;
    endtask
endmodule // spi_host_model

// >>> sim/eeprom_protect_tb_top.sv
// Purpose: self-checking bench for the eeprom protection block
// Assumes: write cycle shortened to 600 sys_clk
// Notes: status snapshots are queued by the driver, compared by a watcher
`timescale 1ns/100ps
`include "eeprom_protect_consts.vh"
module eeprom_protect_tb_top;
    logic sys_clk = 1'b0, rst_n = 1'b0, wprot_n_pin = 1'b1, wr_data_ready = 1'b0;
    wire sel_n_pin, sclk_pin, sdi_pin, pause_n_pin;
    wire sdo_out_q, sdo_oe_n_q, protect_pin_enable, block_protect_hi, block_protect_lo;
    wire write_enable_latch, write_in_progress, wr_data_valid_q, array_commit_q;
    wire write_refused_q, paused_q;
    wire [7:0] status_q, wr_data_q;
    wire [12:0] wr_addr_q;
    integer miscompares = 0, n_checks = 0, exp_commits = 0, act_commits = 0, bp, j;
    integer exp_refusals = 0, act_refusals = 0, n_paused = 0;
    logic [15:0] exp_q[$];
    logic [15:0] e;
    logic [7:0] rd_sh;
    logic [7:0] dat_q[$];
    logic [12:0] addrs[4] = '{13'h17ff, 13'h1800, 13'h0fff, 13'h1000};
    logic prot;
    event chk_ev;
    eeprom_protect #(.WRITE_CYCLES(600)) i_eeprom_protect (.sys_clk, .rst_n, .sel_n_pin,
        .sclk_pin, .sdi_pin, .pause_n_pin, .wprot_n_pin, .sdo_out_q, .sdo_oe_n_q, .status_q,
        .protect_pin_enable, .block_protect_hi, .block_protect_lo, .write_enable_latch,
        .write_in_progress, .wr_addr_q, .wr_data_q, .wr_data_valid_q, .wr_data_ready,
        .array_commit_q, .write_refused_q, .paused_q);
    spi_host_model i_host (.sys_clk, .sel_n(sel_n_pin), .sclk(sclk_pin), .sdi(sdi_pin),
        .pause_n(pause_n_pin));
    initial forever #10 sys_clk = ~sys_clk;
    // random stalls on the byte stream keep the fifo filling and draining
    always @(negedge sys_clk) wr_data_ready <= 1'($urandom);
    always @(posedge sys_clk) if (array_commit_q === 1'b1) act_commits <= act_commits + 1;
    always @(posedge sys_clk) if (write_refused_q === 1'b1) act_refusals <= act_refusals + 1;
    always @(posedge sys_clk) if (paused_q === 1'b1) n_paused <= n_paused + 1;
    // host-side capture of the serial output while the device drives it
    always @(posedge sclk_pin) if (sdo_oe_n_q === 1'b0) rd_sh <= {rd_sh[6:0], sdo_out_q};
    task cmp8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task cmp_cnt(input integer got, input integer exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task cmp_addr(input logic [12:0] got, input logic [12:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // watcher: oldest note against the masked status byte
    always @(chk_ev) begin
        e = exp_q.pop_front();
        cmp8(status_q & e[15:8], e[7:0]);
    end
    // drain watcher: each accepted byte against the oldest byte sent
    always @(posedge sys_clk) begin
        if (wr_data_valid_q === 1'b1 && wr_data_ready === 1'b1) begin
            if (dat_q.size() > 0) cmp8(wr_data_q, dat_q.pop_front());
            else cmp_cnt(1, 0);
        end
    end
    task note(input [7:0] m, input [7:0] v);
        exp_q.push_back({m, v});
        ->chk_ev;
        @(negedge sys_clk);
    endtask
    task settle;
        repeat (12) @(negedge sys_clk);
    endtask
    task close_out;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task wait_idle;
        integer n;
        n = 0;
        while (write_in_progress !== 1'b0 && n < 2000) begin
            @(negedge sys_clk);
            n++;
        end
        if (write_in_progress !== 1'b0) begin
            miscompares++;
            close_out;
        end else begin
            // status byte trails the bits by one cycle
            repeat (2) @(negedge sys_clk);
        end
    endtask
    task write_enable_cmd;
        i_host.frame(`OP_WRITE_ENABLE, 24'h00_0000, 0, 0);
        settle;
    endtask
    task swr(input [7:0] v, input bit pz);
        i_host.frame(`OP_STATUS_WRITE, {16'h0000, v}, 1, pz);
    endtask
    // taken is clear when the write arrives during a write cycle and its opcode is dropped, so no byte is due
    task awr(input [12:0] a, input bit taken);
        logic [7:0] d;
        d = 8'($urandom);
        if (taken) dat_q.push_back(d);
        i_host.frame(`OP_WRITE, {3'b000, a, d}, 3, 0);
        if (taken) cmp_addr(wr_addr_q, a);
    endtask
    // main sequence
    initial begin
        void'($urandom(10809));
        repeat (12) @(negedge sys_clk);
        rst_n = 1'b1;
        settle;
        note(8'hff, 8'h00);
        cmp8({7'h00, sdo_oe_n_q}, 8'h01);
        swr(8'h8c, 0);
        exp_refusals++;
        settle;
        note(8'h8f, 8'h00);
        write_enable_cmd;
        note(8'h02, 8'h02);
        i_host.frame(`OP_WRITE_DISABLE, 24'h00_0000, 0, 0);
        settle;
        note(8'h02, 8'h00);
        for (bp = 0; bp < 4; bp++) begin
            wprot_n_pin = 1'($urandom); // pin is inert while pin-enable is clear
            write_enable_cmd;
            swr({4'h0, bp[1:0], 2'b00}, 0);
            wait_idle;
            note(8'h8f, {4'h0, bp[1:0], 2'b00});
            for (j = 0; j < 4; j++) begin
                write_enable_cmd;
                awr(addrs[j], 1);
                settle;
                prot = bp == 3 || (bp == 2 && addrs[j] >= 13'h1000)
                    || (bp == 1 && addrs[j] >= 13'h1800);
                if (!prot) exp_commits++;
                else exp_refusals++;
                note(8'h01, {7'h00, !prot});
                wait_idle;
            end
        end
        wprot_n_pin = 1'b1;
        write_enable_cmd;
        swr(8'h80, 0);
        awr(13'h0000, 0);
        settle;
        note(8'h01, 8'h01);
        wait_idle;
        note(8'h8f, 8'h80);
        wprot_n_pin = 1'b0;
        write_enable_cmd;
        swr(8'h8c, 0);
        exp_refusals++;
        settle;
        note(8'h8d, 8'h80);
        write_enable_cmd;
        awr(13'h1fff, 1);
        settle;
        exp_commits++;
        note(8'h01, 8'h01);
        wait_idle;
        wprot_n_pin = 1'b1;
        write_enable_cmd;
        swr(8'h8c, 1);
        wprot_n_pin = 1'b0;
        settle;
        note(8'h8d, 8'h8d);
        // status stays readable while the write cycle runs
        i_host.frame(`OP_STATUS_READ, 24'h00_0000, 1, 0);
        cmp8(rd_sh, 8'h8f);
        wait_idle;
        note(8'h8f, 8'h8c);
        cmp_cnt(act_commits, exp_commits);
        cmp_cnt(act_refusals, exp_refusals);
        cmp_cnt(n_paused, 28);
        cmp_cnt(dat_q.size(), 0);
        close_out;
    end
    // hang guard
    initial begin
        repeat (100000) @(posedge sys_clk);
        miscompares++;
        close_out;
    end
endmodule // eeprom_protect_tb_top
bind eeprom_protect eeprom_protect_monitor #(.WRITE_CYCLES(WRITE_CYCLES)) i_mon (.sys_clk,
    .rst_n, .sel_n_pin, .pause_n_pin, .wprot_n_pin, .sdo_oe_n_q, .status_q,
    .protect_pin_enable, .block_protect_hi, .block_protect_lo, .write_enable_latch,
    .write_in_progress, .array_commit_q);
